// >>> src/cxe_defines.svh
// Constants for the exception entry unit: offsets, bit positions, vectors.
// Assumes big-endian bit numbering of 64-bit words is mapped as bit n -> [63-n].
`ifndef CXE_DEFINES_SVH
`define CXE_DEFINES_SVH
// APB register byte offsets
`define CXE_OFF_CTRL 12'h000
`define CXE_OFF_STAT 12'h004
`define CXE_OFF_CFG0_LO 12'h008
`define CXE_OFF_CFG0_HI 12'h00C
`define CXE_OFF_RA_LO 12'h010
`define CXE_OFF_RA_HI 12'h014
`define CXE_OFF_SS_LO 12'h018
`define CXE_OFF_SS_HI 12'h01C
`define CXE_OFF_DFC 12'h020
`define CXE_OFF_DFA_LO 12'h024
`define CXE_OFF_DFA_HI 12'h028
`define CXE_OFF_MSW_LO 12'h02C
`define CXE_OFF_MSW_HI 12'h030
`define CXE_OFF_BASE_LO 12'h034
`define CXE_OFF_BASE_HI 12'h038
`define CXE_OFF_VEC_LO 12'h03C
`define CXE_OFF_VEC_HI 12'h040
// Machine state word bits (LSB-0 index of big-endian bit n is 63-n)
`define CXE_MSW_SF 63
`define CXE_MSW_ME 12
`define CXE_MSW_RI 1
`define CXE_MSW_DR 4
`define CXE_MSW_IR 5
// Config0 bits: big-endian 15 and 32
`define CXE_CFG_NHR 48
`define CXE_CFG_MCPIN 31
// Saved status bits: big-endian 42, 43, 44:45
`define CXE_SS_IFU 21
`define CXE_SS_LSU 20
`define CXE_SS_CAUSE_HI 19
`define CXE_SS_CAUSE_LO 18
// Fault cause (32-bit, big-endian bit n -> [31-n])
`define CXE_DFC_UE 15
`define CXE_DFC_UETW 14
`define CXE_DFC_L1D 13
`define CXE_DFC_L1T 12
`define CXE_DFC_ERAT 11
`define CXE_DFC_TLB 10
`define CXE_DFC_SLB 8
// Vector offsets
`define CXE_VEC_SRESET 64'h0000_0000_0000_0100
`define CXE_VEC_MCHK 64'h0000_0000_0000_0200
`define CXE_VEC_DSTOR 64'h0000_0000_0000_0300
`define CXE_VEC_DSEG 64'h0000_0000_0000_0380
`define CXE_VEC_ISTOR 64'h0000_0000_0000_0400
`define CXE_VEC_ISEG 64'h0000_0000_0000_0480
// Scan-port soft reset command sequence
`define CXE_SCAN_CMD1 8'hA5
`define CXE_SCAN_CMD2 8'h5A
`define CXE_ZERO64 64'h0000_0000_0000_0000
`endif

// >>> src/cxe_pkg.sv
// Types for the exception entry unit.
// Assumes cxe_defines.svh is available for constants.
package cxe_pkg;
	typedef enum logic [2:0] {
		CXE_NONE, CXE_SRESET, CXE_MCHK, CXE_DSTOR, CXE_DSEG, CXE_ISTOR, CXE_ISEG
	} cxe_kind_type;
	// Error reports from the detectors, one cycle pulses
	typedef struct packed {
		logic l1d_par;
		logic l1t_par;
		logic erat_par;
		logic tlb_par;
		logic slb_par;
		logic l2_ue_load;
		logic l2_ue_walk;
		logic ci_bad;
		logic ifu_ue;
		logic if_slb_par;
		logic if_tlb_par;
		logic if_walk_ue;
	} cxe_err_type;
	// Pipeline fault and context inputs
	typedef struct packed {
		logic d_page_fault;
		logic d_seg_miss;
		logic i_fetch_fail;
		logic i_seg_miss;
		logic [63:0] instr_addr;
		logic [63:0] next_addr;
		logic [63:0] ea;
	} cxe_pipe_type;
	// Exception taken report
	typedef struct packed {
		logic taken;
		cxe_kind_type kind;
		logic [63:0] fetch_addr;
		logic checkstop;
	} cxe_take_type;
	typedef struct packed {
		logic [63:0] msw;
		logic [63:0] cfg0;
		logic [63:0] base;
		logic [63:0] ret_addr;
		logic [63:0] saved;
		logic [31:0] dfc;
		logic [63:0] dfa;
		logic [63:0] vec;
		logic l1_sw_mode;
		logic [1:0] scan_st;
		logic checkstop;
		cxe_take_type take;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cxe_state_type;
endpackage

// >>> src/cxe_entry.sv
// Exception entry unit: forms the new machine state word, logs causes, picks vectors.
// Assumes all inputs synchronous to pclk and an APB master for software access.
// Function
// - On any exception clear state word, set 64-bit mode bit.
// - Only machine check clears the machine-check enable bit.
// - Soft reset pin or scan command sequence raises system reset.
// - Not-hard-reset config bit survives soft reset, zero after hard reset.
// - Machine check with enable clear enters checkstop.
// - Machine check pin acts only when config bit 32 set.
// - Data-side parity errors give precise machine check at offending instruction.
// - Default mode fixes L1 data and tag parity without interrupt.
// - L2 uncorrectable error on load or walk gives machine check.
// - Bad data for caching-inhibited load gives machine check.
// - Return address: next instruction, or load, or fetch initiator.
// - Saved status copies prior state; bit 62 kept only if recoverable.
// - Saved status bits 42, 43 flag fetch uncorrectable and load/store errors.
// - Saved status bits 44:45 encode fetch translation error cause.
// - Fault cause zeros; bits 16, 17 flag deferred uncorrectable errors.
// - Fault cause bits 18-21 flag recoverable parity errors.
// - Fault cause bit 23 flags segment buffer parity incl duplicates.
// - Fault address gets effective address for listed errors.
// - Data page fault takes data storage exception at 0x300.
// - Data segment miss with translation on goes to 0x380.
// - Failed fetch takes instruction storage exception at 0x400.
// - Instruction segment miss with translation on goes to 0x480.
// - Handler fetch address is base offset plus vector.
`timescale 1ns/1ps
`include "cxe_defines.svh"
module cxe_entry
	import cxe_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset and check sources
	input wire logic soft_reset,
	input wire logic scan_valid,
	input wire logic [7:0] scan_cmd,
	input wire logic mchk_pin,
	input wire logic recoverable_err,
	// Detectors and pipeline
	input wire cxe_err_type err,
	input wire cxe_pipe_type pipe,
	// Exception taken report
	output cxe_take_type take,
	output logic checkstop
);
	cxe_state_type s_q, s_d;

	// Write one 32-bit half of a 64-bit register with byte strobes
	function automatic logic [63:0] wr_half(input logic [63:0] r, input logic hi,
			input logic [31:0] d, input logic [3:0] st);
		logic [63:0] o;
		o = r;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				if (hi) o[32+8*i +: 8] = d[8*i +: 8];
				else o[8*i +: 8] = d[8*i +: 8];
			end
		end
		return o;
	endfunction

	// New state word on exception entry
	function automatic logic [63:0] new_msw(input logic [63:0] m, input logic is_mc);
		logic [63:0] o;
		o = `CXE_ZERO64;
		o[`CXE_MSW_SF] = 1'b1;
		o[`CXE_MSW_ME] = is_mc ? 1'b0 : m[`CXE_MSW_ME];
		return o;
	endfunction

	logic sreset_ev, mc_sync, mc_async, mc_any, mc_rec, l1_only;

	// Event decode
	always_comb begin
		sreset_ev = soft_reset || (scan_valid && scan_cmd == `CXE_SCAN_CMD2
			&& s_q.scan_st == 2'd1);
		l1_only = (err.l1d_par || err.l1t_par) && !s_q.l1_sw_mode;
		mc_sync = (s_q.l1_sw_mode && (err.l1d_par || err.l1t_par))
			|| err.erat_par || err.tlb_par || err.slb_par
			|| err.l2_ue_load || err.l2_ue_walk
			|| err.ci_bad
			|| err.ifu_ue || err.if_slb_par || err.if_tlb_par || err.if_walk_ue;
		mc_async = mchk_pin && s_q.cfg0[`CXE_CFG_MCPIN];
		mc_any = mc_sync || mc_async;
		mc_rec = recoverable_err && s_q.msw[`CXE_MSW_RI];
	end

	// Next state
	always_comb begin
		logic [63:0] sv;
		logic [11:0] off;
		logic dsel;
		sv = `CXE_ZERO64;
		off = paddr[11:0];
		dsel = psel && penable && !s_q.pready;
		s_d = s_q;
		s_d.take.taken = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (!clk_en) begin
			s_d = s_q;
		end else begin
			// Scan-port command sequence tracker
			if (scan_valid) begin
				s_d.scan_st = (scan_cmd == `CXE_SCAN_CMD1) ? 2'd1 : 2'd0;
			end
			if (s_q.checkstop) begin
				s_d.take.taken = 1'b0;
			end else if (sreset_ev) begin
				s_d.take.taken = 1'b1;
				s_d.take.kind = CXE_SRESET;
				s_d.vec = `CXE_VEC_SRESET;
				s_d.ret_addr = pipe.next_addr;
				s_d.saved = s_q.msw;
				s_d.msw = new_msw(s_q.msw, 1'b0);
				s_d.take.fetch_addr = s_q.base + `CXE_VEC_SRESET;
				// Config bit 15 keeps its value here: no write to cfg0.
			end else if (mc_any && !s_q.msw[`CXE_MSW_ME]) begin
				s_d.checkstop = 1'b1;
			end else if (mc_any) begin
				s_d.take.taken = 1'b1;
				s_d.take.kind = CXE_MCHK;
				s_d.vec = `CXE_VEC_MCHK;
				// Return address choice
				if (err.ifu_ue || err.if_slb_par || err.if_tlb_par || err.if_walk_ue)
					s_d.ret_addr = pipe.instr_addr;
				else if (mc_sync)
					s_d.ret_addr = pipe.instr_addr;
				else
					s_d.ret_addr = pipe.next_addr;
				sv = s_q.msw;
				sv[`CXE_MSW_RI] = mc_rec ? s_q.msw[`CXE_MSW_RI] : 1'b0;
				sv[`CXE_SS_IFU] = err.ifu_ue;
				sv[`CXE_SS_LSU] = mc_sync && !(err.ifu_ue || err.if_slb_par
					|| err.if_tlb_par || err.if_walk_ue);
				// Cause encoding
				{sv[`CXE_SS_CAUSE_HI], sv[`CXE_SS_CAUSE_LO]} =
					err.if_walk_ue ? 2'd3 : err.if_tlb_par ? 2'd2 :
					err.if_slb_par ? 2'd1 : 2'd0;
				s_d.saved = sv;
				s_d.dfc = 32'h0000_0000;
				s_d.dfc[`CXE_DFC_UE] = err.l2_ue_load || err.ci_bad;
				s_d.dfc[`CXE_DFC_UETW] = err.l2_ue_walk;
				s_d.dfc[`CXE_DFC_L1D] = err.l1d_par && s_q.l1_sw_mode;
				s_d.dfc[`CXE_DFC_L1T] = err.l1t_par && s_q.l1_sw_mode;
				s_d.dfc[`CXE_DFC_ERAT] = err.erat_par;
				s_d.dfc[`CXE_DFC_TLB] = err.tlb_par;
				s_d.dfc[`CXE_DFC_SLB] = err.slb_par;
				if (err.erat_par || err.tlb_par || err.slb_par || err.l2_ue_walk
						|| (s_q.l1_sw_mode && (err.l1d_par || err.l1t_par)))
					s_d.dfa = pipe.ea;
				s_d.msw = new_msw(s_q.msw, 1'b1);
				s_d.take.fetch_addr = s_q.base + `CXE_VEC_MCHK;
			end else if (pipe.d_page_fault || (pipe.d_seg_miss && s_q.msw[`CXE_MSW_DR])
					|| pipe.i_fetch_fail || (pipe.i_seg_miss && s_q.msw[`CXE_MSW_IR])) begin
				s_d.take.taken = 1'b1;
				s_d.ret_addr = pipe.instr_addr;
				s_d.saved = s_q.msw;
				s_d.msw = new_msw(s_q.msw, 1'b0);
				if (pipe.d_page_fault) begin
					s_d.take.kind = CXE_DSTOR;
					s_d.vec = `CXE_VEC_DSTOR;
					s_d.dfa = pipe.ea;
				end else if (pipe.d_seg_miss && s_q.msw[`CXE_MSW_DR]) begin
					s_d.take.kind = CXE_DSEG;
					s_d.vec = `CXE_VEC_DSEG;
					s_d.dfa = pipe.ea;
				end else if (pipe.i_seg_miss && s_q.msw[`CXE_MSW_IR]) begin
					s_d.take.kind = CXE_ISEG;
					s_d.vec = `CXE_VEC_ISEG;
				end else begin
					s_d.take.kind = CXE_ISTOR;
					s_d.vec = `CXE_VEC_ISTOR;
				end
				s_d.take.fetch_addr = s_q.base + s_d.vec;
			end
			// Report carries the stop level alongside the taken pulse
			s_d.take.checkstop = s_d.checkstop;
			// APB access; software writes lose to a same-cycle exception update
			if (dsel) begin
				s_d.pready = 1'b1;
				s_d.prdata = 32'h0000_0000;
				unique case (off)
					`CXE_OFF_CTRL: if (pwrite) s_d.l1_sw_mode = pwdata[0];
						else s_d.prdata = {31'h0000_0000, s_q.l1_sw_mode};
					`CXE_OFF_STAT: if (!pwrite) s_d.prdata = {29'h0000_0000,
						s_q.checkstop, s_q.take.taken, l1_only};
					`CXE_OFF_CFG0_LO, `CXE_OFF_CFG0_HI: if (pwrite)
						s_d.cfg0 = wr_half(s_q.cfg0, off[2], pwdata, pstrb);
						else s_d.prdata = off[2] ? s_q.cfg0[63:32] : s_q.cfg0[31:0];
					`CXE_OFF_RA_LO, `CXE_OFF_RA_HI: if (pwrite && !s_d.take.taken)
						s_d.ret_addr = wr_half(s_q.ret_addr, off[2], pwdata, pstrb);
						else s_d.prdata = off[2] ? s_q.ret_addr[63:32] : s_q.ret_addr[31:0];
					`CXE_OFF_SS_LO, `CXE_OFF_SS_HI: if (pwrite && !s_d.take.taken)
						s_d.saved = wr_half(s_q.saved, off[2], pwdata, pstrb);
						else s_d.prdata = off[2] ? s_q.saved[63:32] : s_q.saved[31:0];
					`CXE_OFF_DFC: if (pwrite && !s_d.take.taken) s_d.dfc = pwdata;
						else s_d.prdata = s_q.dfc;
					`CXE_OFF_DFA_LO, `CXE_OFF_DFA_HI: if (pwrite && !s_d.take.taken)
						s_d.dfa = wr_half(s_q.dfa, off[3], pwdata, pstrb);
						else s_d.prdata = off[3] ? s_q.dfa[63:32] : s_q.dfa[31:0];
					`CXE_OFF_MSW_LO, `CXE_OFF_MSW_HI: if (pwrite && !s_d.take.taken)
						s_d.msw = wr_half(s_q.msw, off == `CXE_OFF_MSW_HI, pwdata, pstrb);
						else s_d.prdata = (off == `CXE_OFF_MSW_HI) ? s_q.msw[63:32]
							: s_q.msw[31:0];
					`CXE_OFF_BASE_LO, `CXE_OFF_BASE_HI: if (pwrite)
						s_d.base = wr_half(s_q.base, off[3], pwdata, pstrb);
						else s_d.prdata = off[3] ? s_q.base[63:32] : s_q.base[31:0];
					`CXE_OFF_VEC_LO, `CXE_OFF_VEC_HI: if (!pwrite)
						s_d.prdata = (off == `CXE_OFF_VEC_HI) ? s_q.vec[63:32] : s_q.vec[31:0];
					default: s_d.pslverr = 1'b1;
				endcase
			end
		end
	end

	// State register; hard reset zeroes everything incl. not-hard-reset bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign take = s_q.take;
	assign checkstop = s_q.checkstop;

	// Entry word: mode bit set, enable kept or cleared
	msw_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.take.taken |-> s_q.msw[`CXE_MSW_SF] && s_q.msw[`CXE_MSW_RI] == 1'b0)
		else $error("entry state word wrong");
	me_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.take.taken && s_q.take.kind != CXE_MCHK |-> $stable(s_q.msw[`CXE_MSW_ME]))
		else $error("enable bit changed");
	sreset_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && soft_reset && !s_q.checkstop |=> s_q.take.taken
		&& s_q.take.kind == CXE_SRESET) else $error("soft reset missed");
	stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mc_any && !sreset_ev && !s_q.msw[`CXE_MSW_ME] && !s_q.checkstop
		|=> s_q.checkstop && !s_q.take.taken) else $error("no checkstop");
	pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mchk_pin && !s_q.cfg0[`CXE_CFG_MCPIN] && !mc_sync && !sreset_ev
		&& !(pipe.d_page_fault || pipe.d_seg_miss || pipe.i_fetch_fail || pipe.i_seg_miss)
		|=> !s_q.take.taken) else $error("pin not gated");
	l1_fix_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && l1_only && !mc_any && !sreset_ev
		&& !(pipe.d_page_fault || pipe.d_seg_miss || pipe.i_fetch_fail || pipe.i_seg_miss)
		|=> !s_q.take.taken) else $error("l1 parity interrupted");
	vec_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.take.taken |-> s_q.take.fetch_addr == $past(s_q.base) + s_q.vec)
		else $error("fetch address wrong");
	dstor_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.take.taken && s_q.take.kind == CXE_DSTOR |-> s_q.vec == `CXE_VEC_DSTOR)
		else $error("data storage vector wrong");
endmodule // cxe_entry

// >>> tb/cxe_pipe_model.sv
// Model of the pipeline, error detectors and pins around the exception unit.
// Assumes the bench asks for one event at a time with fire and sel.
`timescale 1ns/1ps
`include "cxe_defines.svh"
module cxe_pipe_model
	import cxe_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Commands from the bench
	input wire logic fire,
	input wire logic [4:0] sel,
	input wire logic rec,
	// Toward the exception unit
	output cxe_err_type err,
	output cxe_pipe_type pipe,
	output logic soft_reset,
	output logic scan_valid,
	output logic [7:0] scan_cmd,
	output logic mchk_pin,
	output logic recoverable_err
);
	logic scan_two_q;
	logic go_scan;

	// Scan command pair starts on this request
	assign go_scan = fire && sel == 5'd18;

	// One-cycle event pulses; idle scan bus toggles so stale data is never seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err <= '0;
			pipe <= '0;
			soft_reset <= 1'b0;
			scan_valid <= 1'b0;
			scan_cmd <= 8'h00;
			mchk_pin <= 1'b0;
			recoverable_err <= 1'b0;
			scan_two_q <= 1'b0;
		end else begin
			err <= (fire && sel < 5'd12) ? cxe_err_type'(12'h800 >> sel) : '0;
			pipe.d_page_fault <= fire && sel == 5'd12;
			pipe.d_seg_miss <= fire && sel == 5'd13;
			pipe.i_fetch_fail <= fire && sel == 5'd14;
			pipe.i_seg_miss <= fire && sel == 5'd15;
			soft_reset <= fire && sel == 5'd16;
			mchk_pin <= fire && sel == 5'd17;
			scan_two_q <= go_scan;
			scan_valid <= go_scan || scan_two_q;
			scan_cmd <= go_scan ? `CXE_SCAN_CMD1 : scan_two_q ? `CXE_SCAN_CMD2 : ~scan_cmd;
			recoverable_err <= rec;
			if (fire) begin
				pipe.instr_addr <= {$urandom, $urandom};
				pipe.next_addr <= {$urandom, $urandom};
				pipe.ea <= {$urandom, $urandom};
			end
		end
	end
endmodule // cxe_pipe_model

// >>> tb/cxe_entry_tb_top.sv
// Bench for the exception entry unit: APB master, reference values, scenarios.
// Assumes the pipeline model issues events and the unit answers APB with pready.
`timescale 1ns/1ps
`include "cxe_defines.svh"
module cxe_entry_tb_top
	import cxe_pkg::*;
;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, fire, rec;
	logic soft_reset, scan_valid, mchk_pin, recoverable_err, checkstop, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] scan_cmd;
	logic [4:0] sel;
	logic [63:0] base, msw, v;
	cxe_err_type err;
	cxe_pipe_type pipe;
	cxe_take_type take, g;
	int bad_count, total_checks, cyc, i;
	cxe_kind_type kk[4] = '{CXE_DSTOR, CXE_DSEG, CXE_ISTOR, CXE_ISEG};
	logic [63:0] vv[4] = '{`CXE_VEC_DSTOR, `CXE_VEC_DSEG, `CXE_VEC_ISTOR, `CXE_VEC_ISEG};
	logic [31:0] dfc_exp[5] = '{32'h0000_2000, 32'h0000_1000, 32'h0000_0800, 32'h0000_0400,
		32'h0000_0100};

	cxe_entry dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
		.scan_valid(scan_valid), .scan_cmd(scan_cmd), .mchk_pin(mchk_pin),
		.recoverable_err(recoverable_err), .err(err), .pipe(pipe), .take(take),
		.checkstop(checkstop));
	cxe_pipe_model far_u (.pclk(pclk), .presetn(presetn), .fire(fire), .sel(sel), .rec(rec),
		.err(err), .pipe(pipe), .soft_reset(soft_reset), .scan_valid(scan_valid),
		.scan_cmd(scan_cmd), .mchk_pin(mchk_pin), .recoverable_err(recoverable_err));

	// Clock at 40 MHz
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready with the request held
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr64(input logic [11:0] a, input logic [63:0] d);
		apb(1'b1, a, d[31:0], r, e);
		apb(1'b1, a + 12'h004, d[63:32], r, e);
	endtask

	task automatic rd64(input logic [11:0] a, output logic [63:0] d);
		apb(1'b0, a, 32'h0000_0000, d[31:0], e);
		apb(1'b0, a + 12'h004, 32'h0000_0000, d[63:32], e);
	endtask

	// Ask the far side for one event and catch the taken report
	task automatic ev(input logic [4:0] s, output cxe_take_type t);
		t = '0;
		@(posedge pclk);
		fire <= 1'b1;
		sel <= s;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (6) begin
			@(posedge pclk);
			#1;
			if (take.taken === 1'b1) t = take;
		end
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, fire, rec} = '0;
		paddr = '0;
		pwdata = '0;
		sel = '0;
		void'($urandom(16));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd64(`CXE_OFF_CFG0_LO, v);
		chk(v, 64'h0);
		apb(1'b0, 12'hFFC, 32'h0000_0000, r, e);
		chk(64'(e), 64'h1);
		base = {$urandom, $urandom};
		wr64(`CXE_OFF_BASE_LO, base);
		// Storage and segment faults with both translations on
		for (i = 0; i < 4; i++) begin
			msw = {$urandom, $urandom} | 64'h30;
			wr64(`CXE_OFF_MSW_LO, msw);
			ev(5'(12 + i), g);
			chk(64'(g.kind), 64'(kk[i]));
			chk(g.fetch_addr, base + vv[i]);
			rd64(`CXE_OFF_MSW_LO, v);
			chk(v, 64'h8000_0000_0000_0000 | (msw & 64'h1000));
			rd64(`CXE_OFF_VEC_LO, v);
			chk(v, vv[i]);
		end
		// Segment misses are ignored while translation is off
		wr64(`CXE_OFF_MSW_LO, 64'h0);
		ev(5'd13, g);
		chk(64'(g.taken), 64'h0);
		ev(5'd15, g);
		chk(64'(g.taken), 64'h0);
		// Data-side parity checks in software-recovery mode
		apb(1'b1, `CXE_OFF_CTRL, 32'h0000_0001, r, e);
		for (i = 0; i < 5; i++) begin
			msw = {$urandom, $urandom} | 64'h1000;
			rec <= i[0];
			wr64(`CXE_OFF_MSW_LO, msw);
			ev(5'(i), g);
			chk(g.fetch_addr, base + `CXE_VEC_MCHK);
			rd64(`CXE_OFF_RA_LO, v);
			chk(v, pipe.instr_addr);
			rd64(`CXE_OFF_SS_LO, v);
			chk(v, (msw & ~64'h3C_0002) | 64'h10_0000 | (i[0] ? msw & 64'h2 : 64'h0));
			apb(1'b0, `CXE_OFF_DFC, 32'h0000_0000, r, e);
			chk(64'(r), 64'(dfc_exp[i]));
			rd64(`CXE_OFF_DFA_LO, v);
			chk(v, pipe.ea);
			rd64(`CXE_OFF_MSW_LO, v);
			chk(v, 64'h8000_0000_0000_0000);
		end
		// L2, inhibited-load and fetch-side checks
		for (i = 5; i < 12; i++) begin
			wr64(`CXE_OFF_MSW_LO, 64'h1000);
			ev(5'(i), g);
			chk(64'(g.kind), 64'(CXE_MCHK));
			rd64(`CXE_OFF_SS_LO, v);
			if (i >= 8) chk(64'(v[21:18]), 64'(i == 8) << 3 | 64'(i - 8));
		end
		// Default mode repairs L1 parity silently
		apb(1'b1, `CXE_OFF_CTRL, 32'h0000_0000, r, e);
		wr64(`CXE_OFF_MSW_LO, 64'h1000);
		ev(5'd0, g);
		chk(64'(g.taken), 64'h0);
		ev(5'd1, g);
		chk(64'(g.taken), 64'h0);
		// Check pin gated by the config bit
		ev(5'd17, g);
		chk(64'(g.taken), 64'h0);
		wr64(`CXE_OFF_CFG0_LO, 64'h0001_0000_8000_0000);
		ev(5'd17, g);
		chk(64'(g.kind), 64'(CXE_MCHK));
		// Clock enable low freezes the unit through a soft reset pulse
		@(posedge pclk);
		clk_en <= 1'b0;
		ev(5'd16, g);
		chk(64'(g.taken), 64'h0);
		@(posedge pclk);
		clk_en <= 1'b1;
		// Soft reset by pin and by scan command pair
		ev(5'd16, g);
		chk(64'(g.kind), 64'(CXE_SRESET));
		chk(g.fetch_addr, base + `CXE_VEC_SRESET);
		ev(5'd18, g);
		chk(64'(g.kind), 64'(CXE_SRESET));
		rd64(`CXE_OFF_CFG0_LO, v);
		chk(v, 64'h0001_0000_8000_0000);
		// Check with enable clear stops the machine
		wr64(`CXE_OFF_MSW_LO, 64'h0);
		ev(5'd3, g);
		chk(64'(g.taken), 64'h0);
		chk(64'(checkstop), 64'h1);
		chk(64'(take.checkstop), 64'h1);
		apb(1'b0, `CXE_OFF_STAT, 32'h0000_0000, r, e);
		chk(64'(r[2]), 64'h1);
		// Hard reset clears the not-hard-reset bit
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd64(`CXE_OFF_CFG0_LO, v);
		chk(v, 64'h0);
		tally_and_finish();
	end
endmodule // cxe_entry_tb_top
